//--- hdl/afs_pkg.sv
// Shared constants, types and carriers of the amplifier fault supervisor
package afs_pkg;

   // Clock rate and timing
   localparam int CLK_HZ = 25_000_000;
   localparam int OVLD_TIME_US = 2100;
   localparam int OVLD_CYCLES = OVLD_TIME_US * (CLK_HZ / 1_000_000);
   localparam int FLIP_FRAMES = 3;
   localparam int FRAME_CYCLES = 64;
   localparam int SYNC_TIMEOUT = 256;
   localparam int STARTUP_CYCLES = 1024;
   localparam int CHANNELS = 2;

   // Register byte offsets
   localparam logic [7:0] CTRL_OFS = 8'h00;
   localparam logic [7:0] STATUS_OFS = 8'h04;
   localparam logic [7:0] IRQ_STAT_OFS = 8'h08;
   localparam logic [7:0] IRQ_MASK_OFS = 8'h0C;

   // Control fields
   localparam int CTRL_PERIPH = 0;

   // Event bits of status and mask
   localparam int EV_WARN = 0;
   localparam int EV_SHUT = 1;
   localparam int EV_VOLT = 2;
   localparam int EV_OVLD = 3;
   localparam int EV_SYNC = 4;
   localparam int EV_N = 5;

   // Live status fields
   localparam int ST_FAULT = 0;
   localparam int ST_LATCH = 1;
   localparam int ST_SYNC = 2;
   localparam int ST_RUNNING = 3;
   localparam int ST_WARN = 4;
   localparam int ST_OVL = 8;

   // Reset values
   localparam logic CTRL_RST = 1'b0;
   localparam logic [EV_N-1:0] MASK_RST = 5'h00;

   // Startup sequencer states
   typedef enum logic [2:0]
   {
      ST_HOLD = 3'b001,
      ST_START = 3'b010,
      ST_RUN = 3'b100
   } afs_run_e;

   // Threshold comparator flags, all active high
   typedef struct packed
   {
      logic thermal_warning;
      logic thermal_trip;
      logic analog_undervoltage;
      logic power_undervoltage;
      logic overvoltage_trip;
      logic power_on_clear;
   } afs_flags_s;

endpackage

//--- hdl/afs_sync.sv
// Two-stage synchroniser for a bundle of levels
module afs_sync
#(
   parameter int W = 1
)
(
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic [W-1:0] d,
   output logic [W-1:0] q
);
   import afs_pkg::*;

   // Both stages as one state word
   typedef struct packed
   {
      logic [W-1:0] s1;
      logic [W-1:0] s2;
   } afs_sync_s;

   afs_sync_s s_reg;
   afs_sync_s s_next;

   // Width check
   if (W < 1)
   begin : g_bad
      $error("afs_sync: width below one");
   end

   // Stage one feeds stage two only
   always_comb
   begin
      s_next.s1 = d;
      s_next.s2 = s_reg.s1;
   end

   // State register
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
         s_reg <= '0;
      else
         s_reg <= s_next;
   end

   assign q = s_reg.s2;

endmodule

//--- hdl/afs_tick.sv
// Divider giving the one-cycle switching frame enable
module afs_tick
#(
   parameter int DIV = afs_pkg::FRAME_CYCLES
)
(
   input wire logic hclk,
   input wire logic hresetn,
   output logic tick
);
   import afs_pkg::*;

   localparam int CW = $clog2(DIV);

   // Counter and registered pulse
   typedef struct packed
   {
      logic [CW-1:0] cnt;
      logic tick;
   } afs_tick_s;

   afs_tick_s s_reg;
   afs_tick_s s_next;

   // Divide ratio check
   if (DIV < 2)
   begin : g_bad
      $error("afs_tick: divide ratio below two");
   end

   // Wrap and pulse once per frame
   always_comb
   begin
      s_next = s_reg;
      if (s_reg.cnt == CW'(DIV - 1))
      begin
         s_next.cnt = '0;
         s_next.tick = 1'b1;
      end
      else
      begin
         s_next.cnt = s_reg.cnt + 1'b1;
         s_next.tick = 1'b0;
      end
   end

   // State register
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
         s_reg <= '0;
      else
         s_reg <= s_next;
   end

   assign tick = s_reg.tick;

endmodule

//--- hdl/afs_top.sv
// Amplifier fault supervisor with AHB-Lite registers and interrupt
//
// Implementation choices: the register addresses and the AHB-Lite interface to the registers.
module afs_top
#(
   parameter int CH = afs_pkg::CHANNELS,
   parameter int OVLD_LIMIT = afs_pkg::OVLD_CYCLES,
   parameter int FRAME_DIV = afs_pkg::FRAME_CYCLES,
   parameter int SYNC_LIMIT = afs_pkg::SYNC_TIMEOUT
)
(
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   output logic irq,
   input wire afs_pkg::afs_flags_s thresh,
   input wire logic [CH-1:0] over_current,
   input wire logic [CH-1:0] clip_detect,
   input wire logic sync_clock_pin,
   input wire logic device_reset_n,
   output logic fault_n,
   output logic thermal_clip_warn_n,
   output logic [CH-1:0] bridge_hiz,
   output logic [CH-1:0] pwm_enable,
   output logic [CH-1:0] bridge_flip
);
   import afs_pkg::*;

   localparam int OVW = $clog2(OVLD_LIMIT + 1);
   localparam int SYW = $clog2(SYNC_LIMIT + 1);
   localparam int STW = $clog2(STARTUP_CYCLES + 1);
   localparam int NS = 8 + 2 * CH;

   // Whole state of the supervisor
   typedef struct packed
   {
      afs_run_e st;
      logic [STW-1:0] cnt;
      logic thermal_shutdown_latch;
      logic [CH-1:0] overload_shutdown;
      logic [CH-1:0][OVW-1:0] ovc;
      logic [CH-1:0][1:0] fcnt;
      logic [CH-1:0] limit_flip;
      logic sync_d;
      logic [SYW-1:0] scnt;
      logic lost;
      logic periph;
      logic [EV_N-1:0] ev_d;
      logic [EV_N-1:0] irq_st;
      logic [EV_N-1:0] irq_mask;
      logic wr_pend;
      logic [7:0] wr_ofs;
      logic [31:0] rdata;
   } afs_state_s;

   afs_state_s s_reg;
   afs_state_s s_next;

   // Synchronised pins
   afs_flags_s flg;
   logic [CH-1:0] oc_q;
   logic [CH-1:0] clip_q;
   logic sync_q;
   logic rst_hi;
   logic [NS-1:0] sync_out;

   // Derived fault levels
   logic undervoltage_trip;
   logic gfault;
   logic report;
   logic stop_all;
   logic tick;
   logic [EV_N-1:0] ev;
   logic [EV_N-1:0] w1c;
   logic [31:0] rd_val;
   logic [7:0] ofs;
   logic acc;

   // Per-channel next values
   logic [CH-1:0][OVW-1:0] ovc_nx;
   logic [CH-1:0] ovl_nx;
   logic [CH-1:0][1:0] fc_nx;
   logic [CH-1:0] flip_nx;

   // Parameter checks
   if (CH < 1 || CH > 8 || OVLD_LIMIT < 2 || SYNC_LIMIT < 2)
   begin : g_bad
      $error("afs_top: unsupported parameter value");
   end

   afs_sync #(.W(NS)) u_sync
   (
      .hclk(hclk),
      .hresetn(hresetn),
      .d({thresh, over_current, clip_detect, sync_clock_pin,
          device_reset_n}),
      .q(sync_out)
   );

   assign {flg, oc_q, clip_q, sync_q, rst_hi} = sync_out;

   // Switching frame enable
   afs_tick #(.DIV(FRAME_DIV)) u_tick
   (
      .hclk(hclk),
      .hresetn(hresetn),
      .tick(tick)
   );

   // Per-channel overload and limiting
   for (genvar c = 0; c < CH; c++)
   begin : g_ch
      logic at_lim;
      logic fc_last;
      assign at_lim = s_reg.ovc[c] == OVW'(OVLD_LIMIT - 1);
      assign fc_last = s_reg.fcnt[c] == 2'(FLIP_FRAMES - 1);
      assign ovc_nx[c] = (oc_q[c] && !s_reg.overload_shutdown[c]) ?
                         s_reg.ovc[c] + 1'b1 : '0;
      assign ovl_nx[c] = (oc_q[c] && at_lim) ||
                         (s_reg.overload_shutdown[c] && rst_hi);
      assign fc_nx[c] = !oc_q[c] ? 2'h0 :
                        !tick ? s_reg.fcnt[c] :
                        fc_last ? 2'h0 : s_reg.fcnt[c] + 2'h1;
      assign flip_nx[c] = oc_q[c] &&
                          (s_reg.limit_flip[c] ^ (tick && fc_last));
   end

   assign undervoltage_trip = flg.analog_undervoltage |
                              flg.power_undervoltage;

   assign gfault = s_reg.thermal_shutdown_latch | flg.thermal_trip |
                   undervoltage_trip | flg.overvoltage_trip |
                   flg.power_on_clear;
   assign report = gfault | (|s_reg.overload_shutdown);
   assign stop_all = (s_reg.st != ST_RUN) | gfault | s_reg.lost | !rst_hi;

   // Interrupt sources
   assign ev[EV_WARN] = flg.thermal_warning;
   assign ev[EV_SHUT] = s_reg.thermal_shutdown_latch;
   assign ev[EV_VOLT] = undervoltage_trip | flg.overvoltage_trip |
                        flg.power_on_clear;
   assign ev[EV_OVLD] = |s_reg.overload_shutdown;
   assign ev[EV_SYNC] = s_reg.lost;

   // Bus address phase decode
   assign acc = hsel & hready & htrans[1];
   assign ofs = (haddr[31:8] == 24'h000000) ? haddr[7:0] : 8'hFF;

   // Next state of everything
   always_comb
   begin
      s_next = s_reg;
      w1c = '0;
      rd_val = '0;
      case (s_reg.st)
         ST_HOLD:
         begin
            if (rst_hi)
            begin
               s_next.st = ST_START;
               s_next.cnt = '0;
            end
         end
         ST_START:
         begin
            if (s_reg.cnt == STW'(STARTUP_CYCLES - 1))
               s_next.st = ST_RUN;
            else
               s_next.cnt = s_reg.cnt + 1'b1;
         end
         ST_RUN:
         begin
            s_next.st = ST_RUN;
         end
         default:
         begin
            s_next.st = ST_HOLD;
         end
      endcase
      // Reset pin held low parks the sequencer
      if (!rst_hi)
      begin
         s_next.st = ST_HOLD;
         s_next.cnt = '0;
      end
      s_next.thermal_shutdown_latch = flg.thermal_trip |
         (s_reg.thermal_shutdown_latch & rst_hi);
      s_next.ovc = ovc_nx;
      s_next.overload_shutdown = ovl_nx;
      s_next.fcnt = fc_nx;
      s_next.limit_flip = flip_nx;
      s_next.sync_d = sync_q;
      if (!s_reg.periph)
      begin
         s_next.scnt = '0;
         s_next.lost = 1'b0;
      end
      else if (sync_q && !s_reg.sync_d)
      begin
         s_next.scnt = '0;
         s_next.lost = 1'b0;
      end
      else if (s_reg.scnt == SYW'(SYNC_LIMIT - 1))
         s_next.lost = 1'b1;
      else
         s_next.scnt = s_reg.scnt + 1'b1;
      // Register write in data phase
      if (s_reg.wr_pend)
      begin
         case (s_reg.wr_ofs)
            CTRL_OFS:
               s_next.periph = hwdata[CTRL_PERIPH];
            IRQ_STAT_OFS:
               w1c = hwdata[EV_N-1:0];
            IRQ_MASK_OFS:
               s_next.irq_mask = hwdata[EV_N-1:0];
            default:
               w1c = '0;
         endcase
      end
      // Sticky events, set beats clear
      s_next.ev_d = ev;
      s_next.irq_st = (s_reg.irq_st & ~w1c) | (ev & ~s_reg.ev_d);
      // Read value, unmapped reads zero
      case (ofs)
         CTRL_OFS:
            rd_val[CTRL_PERIPH] = s_reg.periph;
         STATUS_OFS:
         begin
            rd_val[ST_FAULT] = report;
            rd_val[ST_LATCH] = s_reg.thermal_shutdown_latch;
            rd_val[ST_SYNC] = s_reg.lost;
            rd_val[ST_RUNNING] = s_reg.st == ST_RUN;
            rd_val[ST_WARN] = !thermal_clip_warn_n;
            rd_val[ST_OVL +: CH] = s_reg.overload_shutdown;
         end
         IRQ_STAT_OFS:
            rd_val[EV_N-1:0] = s_reg.irq_st;
         IRQ_MASK_OFS:
            rd_val[EV_N-1:0] = s_reg.irq_mask;
         default:
            rd_val = '0;
      endcase
      // Address phase capture
      s_next.wr_pend = acc & hwrite;
      if (acc)
         s_next.wr_ofs = ofs;
      if (acc && !hwrite)
         s_next.rdata = rd_val;
   end

   // State register
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         s_reg <= '0;
         s_reg.st <= ST_HOLD;
         s_reg.periph <= CTRL_RST;
         s_reg.irq_mask <= MASK_RST;
      end
      else
         s_reg <= s_next;
   end

   assign fault_n = !(report && rst_hi);
   assign thermal_clip_warn_n = !(flg.thermal_warning | (|clip_q));
   assign bridge_hiz = {CH{stop_all}} | s_reg.overload_shutdown;
   assign pwm_enable = ~bridge_hiz;
   assign bridge_flip = s_reg.limit_flip & ~bridge_hiz;
   assign irq = |(s_reg.irq_st & s_reg.irq_mask);
   assign hrdata = s_reg.rdata;
   assign hreadyout = 1'b1;
   assign hresp = 1'b0;

   // Checks on one clock domain
   default clocking cb @(posedge hclk);
   endclocking
   default disable iff (!hresetn);

   sequence rst_rise_s;
      $rose(rst_hi) && s_reg.st == ST_HOLD;
   endsequence

   sequence start_end_s;
      s_reg.st == ST_START && rst_hi &&
      s_reg.cnt == STW'(STARTUP_CYCLES - 1);
   endsequence

   warn_pin_a:
   assert property (flg.thermal_warning |-> !thermal_clip_warn_n)
      else $error("warning pin not low");

   shut_stop_a:
   assert property (flg.thermal_trip && rst_hi
                    |-> !fault_n && &bridge_hiz ##1
                        s_reg.thermal_shutdown_latch)
      else $error("thermal shutdown not applied");

   shut_hold_a:
   assert property (s_reg.thermal_shutdown_latch && rst_hi
                    |=> s_reg.thermal_shutdown_latch && &bridge_hiz)
      else $error("shutdown latch lost without reset");

   uv_stop_a:
   assert property (undervoltage_trip |-> &bridge_hiz)
      else $error("undervoltage left a bridge on");

   ov_fault_a:
   assert property (flg.overvoltage_trip && rst_hi
                    |-> !fault_n && &bridge_hiz)
      else $error("overvoltage not reported");

   rst_fault_a:
   assert property (!rst_hi |-> fault_n && &bridge_hiz)
      else $error("fault pin low during reset");

   chan_local_a:
   assert property (!stop_all |-> bridge_hiz == s_reg.overload_shutdown)
      else $error("channel fault not local");

   flip_step_a:
   assert property (oc_q[0] && tick && !s_reg.limit_flip[0] &&
                    s_reg.fcnt[0] == 2'(FLIP_FRAMES - 1)
                    |=> s_reg.limit_flip[0])
      else $error("limit flip missed");

   flip_hold_a:
   assert property (oc_q[0] && !tick |=> $stable(s_reg.limit_flip[0]))
      else $error("limit flip between frames");

   sync_quiet_a:
   assert property (s_reg.lost && !report && rst_hi
                    |-> &bridge_hiz && fault_n)
      else $error("sync loss mishandled");

   start_go_a:
   assert property (rst_rise_s |=> s_reg.st == ST_START ##1
                    s_reg.st == ST_START || !rst_hi)
      else $error("startup not entered");

   start_done_a:
   assert property (start_end_s |=> s_reg.st == ST_RUN)
      else $error("startup did not finish");

   ovl_set_a:
   assert property (oc_q[0] && s_reg.ovc[0] == OVW'(OVLD_LIMIT - 1)
                    |=> s_reg.overload_shutdown[0] && bridge_hiz[0])
      else $error("overload not latched");

   ovl_hold_a:
   assert property (s_reg.overload_shutdown[0] && rst_hi
                    |=> s_reg.overload_shutdown[0] && fault_n == !rst_hi)
      else $error("overload cleared without reset");

endmodule

//--- sim/afs_mcu.sv
// Controller model that watches the fault pins and drives reset
module afs_mcu
#(
   parameter int WAIT_CYC = 100000
)
(
   input wire logic hclk,
   input wire logic rst_req,
   input wire logic fault_n,
   input wire logic thermal_clip_warn_n,
   output logic device_reset_n = 1'h1
);
   timeunit 1ns;
   timeprecision 100ps;
   // Cycles since the fault pin last fell, 4 ms at 25 MHz by default
   int since_fall = WAIT_CYC;
   // Fault pin one cycle back
   logic fault_q = 1'h1;
   // Track the fault fall, then hold or release reset
   always @(posedge hclk)
   begin
      fault_q <= fault_n;
      if (fault_q && !fault_n)
         since_fall <= 0;
      else if (since_fall < WAIT_CYC)
         since_fall <= since_fall + 1;
      if (rst_req)
         device_reset_n <= 1'h0;
      // release only when cool and late enough
      else if (thermal_clip_warn_n === 1'h1 && since_fall >= WAIT_CYC)
         device_reset_n <= 1'h1;
   end
endmodule

//--- sim/testbench.sv
// Self-checking bench of the amplifier fault supervisor
module testbench;
   timeunit 1ns;
   timeprecision 100ps;
   import afs_pkg::*;
   // Shortened counts for a quick run
   localparam int SYNC = 16;
   // One table row: flags in, pins expected
   typedef struct packed
   {
      afs_flags_s f;
      logic fault_n;
      logic [1:0] hiz;
      logic warn_n;
   } afs_row_s;
   afs_row_s rows [5] = '{
      '{6'h20, 1'h1, 2'h0, 1'h0},
      '{6'h08, 1'h0, 2'h3, 1'h1},
      '{6'h04, 1'h0, 2'h3, 1'h1},
      '{6'h02, 1'h0, 2'h3, 1'h1},
      '{6'h01, 1'h0, 2'h3, 1'h1}};
   logic hclk, hresetn, hsel, hwrite, sync_on, rst_req, seen, flt;
   logic [31:0] haddr, hwdata, hrdata, q;
   logic [1:0] htrans, over_current, clip_detect, bridge_hiz;
   logic [1:0] pwm_enable, bridge_flip;
   logic [2:0] hsize;
   logic hreadyout, hresp, irq, sync_clock_pin, device_reset_n;
   logic fault_n, thermal_clip_warn_n;
   afs_flags_s thresh;
   int n_fail = 0;
   int compares = 0;
   afs_top #(.CH(2), .OVLD_LIMIT(20), .FRAME_DIV(4), .SYNC_LIMIT(SYNC))
      dut_u (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
      .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
      .hresp(hresp), .irq(irq), .thresh(thresh),
      .over_current(over_current), .clip_detect(clip_detect),
      .sync_clock_pin(sync_clock_pin), .device_reset_n(device_reset_n),
      .fault_n(fault_n), .thermal_clip_warn_n(thermal_clip_warn_n),
      .bridge_hiz(bridge_hiz), .pwm_enable(pwm_enable),
      .bridge_flip(bridge_flip));
   afs_mcu #(.WAIT_CYC(200)) mcu_u (.hclk(hclk), .rst_req(rst_req),
      .fault_n(fault_n), .thermal_clip_warn_n(thermal_clip_warn_n),
      .device_reset_n(device_reset_n));
   // Bus clock, 40 ns period
   always #20 hclk = ~hclk;
   // Divider phase of the external sync clock
   int sdiv = 0;
   // External sync clock, a toggle every third rising bus clock edge
   always @(posedge hclk)
   begin
      sdiv <= (sdiv == 2) ? 0 : sdiv + 1;
      if (sync_on && sdiv == 2)
         sync_clock_pin <= ~sync_clock_pin;
   end
   // Counts and verdict, then stop
   task automatic wrap_up();
      $display("Comparisons %0d mismatches %0d", compares, n_fail);
      if (n_fail == 0 && compares > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask
   // A bounded wait ran out
   task automatic tmo();
      n_fail++;
      $display("BAD wait expected done seen timeout");
      wrap_up();
   endtask
   // Compare one result
   task automatic cmp(input string nm, input logic [31:0] e, g);
      compares++;
      if (g !== e)
      begin
         n_fail++;
         $display("BAD %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic tk(input int n);
      repeat (n) @(posedge hclk);
   endtask
   // One single AHB-Lite transfer, address then data phase
   task automatic bus(input logic w, input logic [31:0] a, d);
      int k;
      k = 0;
      haddr <= a;
      hwrite <= w;
      htrans <= 2'h2;
      hsel <= 1'h1;
      tk(1);
      while (hreadyout !== 1'h1 && k < 20)
      begin
         tk(1);
         k++;
      end
      htrans <= 2'h0;
      hwdata <= d;
      tk(1);
      while (hreadyout !== 1'h1 && k < 40)
      begin
         tk(1);
         k++;
      end
      q = hrdata;
      cmp("hresp", 32'h0, hresp);
      if (k >= 40)
         tmo();
   endtask
   // Wait for switching and check the startup length
   task automatic wait_run();
      int k;
      k = 0;
      while (pwm_enable !== 2'h3 && k < 1200)
      begin
         tk(1);
         k++;
      end
      cmp("startup", 1'h1,
          k >= STARTUP_CYCLES && k <= STARTUP_CYCLES + 16);
      if (k >= 1200)
         tmo();
   endtask
   // Reset cycle through the controller; hot keeps the warning up a while
   task automatic dev_reset(input logic hot);
      int k;
      rst_req <= 1'h1;
      tk(6);
      cmp("fault_n_rst", 1'h1, fault_n);
      rst_req <= 1'h0;
      if (hot)
      begin
         tk(300);
         cmp("hiz_held", 2'h3, bridge_hiz);
         thresh <= '0;
      end
      k = 0;
      while (device_reset_n !== 1'h1 && k < 400)
      begin
         tk(1);
         k++;
      end
      if (k >= 400)
         tmo();
      wait_run();
      cmp("restart_fault_n", 1'h1, fault_n);
   endtask
   // Main sequence
   initial
   begin
      hclk = 1'h0;
      hresetn = 1'h0;
      hsel = 1'h0;
      haddr = 32'h0;
      htrans = 2'h0;
      hwrite = 1'h0;
      hsize = 3'h2;
      hwdata = 32'h0;
      thresh = '0;
      over_current = 2'h0;
      clip_detect = 2'h0;
      sync_clock_pin = 1'h0;
      sync_on = 1'h1;
      rst_req = 1'h0;
      tk(4);
      cmp("rst_pins", 4'hE, {fault_n, bridge_hiz, irq});
      hresetn <= 1'h1;
      wait_run();
      // Table of self-clearing faults and the warning
      foreach (rows[i])
      begin
         thresh <= rows[i].f;
         tk(2);
         cmp("two_flop", 4'hC,
             {fault_n, thermal_clip_warn_n, bridge_hiz});
         tk(2);
         cmp("fault_n", rows[i].fault_n, fault_n);
         cmp("hiz", rows[i].hiz, bridge_hiz);
         cmp("warn_n", rows[i].warn_n, thermal_clip_warn_n);
         thresh <= '0;
         tk(4);
         cmp("recover", 3'h4, {fault_n, bridge_hiz});
      end
      // Events stay masked until the mask is written, then W1C
      cmp("irq_masked", 1'h0, irq);
      bus(1'h0, {24'h0, IRQ_STAT_OFS}, 32'h0);
      cmp("irq_stat", 32'h5, q);
      bus(1'h1, {24'h0, IRQ_MASK_OFS}, 32'h1F);
      tk(2);
      cmp("irq_on", 1'h1, irq);
      bus(1'h1, {24'h0, IRQ_STAT_OFS}, 32'h5);
      tk(2);
      cmp("irq_off", 1'h0, irq);
      bus(1'h1, 32'h100, 32'hF);
      bus(1'h0, 32'h100, 32'h0);
      cmp("unmapped", 32'h0, q);
      // Clip pulses on the warning pin
      clip_detect <= 2'h2;
      tk(3);
      cmp("clip_warn", 1'h0, thermal_clip_warn_n);
      cmp("clip_run", 2'h3, pwm_enable);
      clip_detect <= 2'h0;
      tk(3);
      cmp("clip_clear", 1'h1, thermal_clip_warn_n);
      // Thermal shutdown with warning, latched until reset
      thresh <= 6'h30;
      tk(4);
      cmp("shut_fault_n", 1'h0, fault_n);
      cmp("shut_pwm", 2'h0, pwm_enable);
      thresh <= 6'h20;
      tk(8);
      cmp("shut_latch", 3'h3, {fault_n, bridge_hiz});
      dev_reset(1'h1);
      // Short overcurrent: flipping, nothing reported
      over_current <= 2'h1;
      seen = 1'h0;
      flt = 1'h1;
      repeat (17)
      begin
         tk(1);
         seen = seen | bridge_flip[0];
         flt = flt & fault_n;
      end
      over_current <= 2'h0;
      cmp("flip_seen", 1'h1, seen);
      cmp("cl_fault_n", 1'h1, flt);
      tk(4);
      cmp("flip_clear", 2'h0, bridge_flip);
      // Lasting overcurrent latches channel 0 only
      over_current <= 2'h1;
      tk(30);
      cmp("ovl_hiz", 2'h1, bridge_hiz);
      cmp("ovl_pwm", 2'h2, pwm_enable);
      cmp("ovl_fault_n", 1'h0, fault_n);
      over_current <= 2'h0;
      tk(6);
      cmp("ovl_latch", 2'h1, bridge_hiz);
      // Status: fault reported, running, channel 0 overload
      bus(1'h0, {24'h0, STATUS_OFS}, 32'h0);
      cmp("status", 32'h109, q);
      dev_reset(1'h0);
      // Sync watchdog: lost clock turns bridges off silently
      bus(1'h1, {24'h0, CTRL_OFS}, 32'h1);
      bus(1'h0, {24'h0, CTRL_OFS}, 32'h0);
      cmp("ctrl", 32'h1, q);
      tk(4);
      cmp("sync_ok", 2'h0, bridge_hiz);
      sync_on <= 1'h0;
      tk(SYNC + 12);
      cmp("sync_lost", 3'h7, {fault_n, bridge_hiz});
      sync_on <= 1'h1;
      tk(12);
      cmp("sync_back", 2'h0, bridge_hiz);
      wrap_up();
   end
endmodule
